// file: gimc_assertions.sv
`timescale 1ns/10ps
// Watches flags, mask, clear and reads at the block's ports.
module gimc_chk (input wire sys_clk, rst_b, reg_wr, reg_rd, gauge_irq,
  input wire [7:0]  reg_addr,
  input wire [15:0] reg_wdata, reg_rdata, event_pulse, event_flags, event_flag_mask,
  input wire [15:0] event_pending);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // A clear write followed by a cycle without events, then the checks.
  sequence s_clr; reg_wr && reg_addr == 8'h0C ##1 !event_pulse; endsequence
  property p_pd; event_pending == (event_flags & ~event_flag_mask); endproperty
  a_pd: assert property (p_pd) else $error("pending wrong");
  property p_irq; gauge_irq == |event_pending; endproperty
  a_irq: assert property (p_irq) else $error("irq wrong");
  property p_set; |event_pulse |=> &(event_flags | ~$past(event_pulse)); endproperty
  a_set: assert property (p_set) else $error("flag not set");
  property p_hold; |($past(event_flags) & ~event_flags) |-> $past(reg_wr, 2); endproperty
  a_hold: assert property (p_hold) else $error("flag dropped");
  property p_clr; s_clr |=> !(event_flags & $past(reg_wdata, 2)); endproperty
  a_clr: assert property (p_clr) else $error("flag not cleared");
  property p_msk; reg_wr && reg_addr == 8'h0B |=> event_flag_mask == $past(reg_wdata); endproperty
  a_msk: assert property (p_msk) else $error("mask wrong");
  property p_rf; reg_rd && reg_addr == 8'h0A |=> reg_rdata == $past(event_flags); endproperty
  a_rf: assert property (p_rf) else $error("flag read wrong");
  property p_rc; reg_rd && reg_addr == 8'h0C && !$past(reg_wr) |=> !reg_rdata; endproperty
  a_rc: assert property (p_rc) else $error("clear not zero");
endmodule
bind gimc_gauge_interrupt_mask_clear gimc_chk chk_u (.*);

// file: gimc_consts.vh
`ifndef GIMC_CONSTS_VH
`define GIMC_CONSTS_VH

// Register offsets on the gauge register port.
`define GIMC_ADDR_W          8
`define GIMC_OFS_FLAGS       8'h0A
`define GIMC_OFS_MASK        8'h0B
`define GIMC_OFS_CLEAR       8'h0C

// Register width and reset values.
`define GIMC_REG_W           16
`define GIMC_FLAGS_RST       16'h0000
`define GIMC_MASK_RST        16'h0000
`define GIMC_CLEAR_RST       16'h0000
`define GIMC_RDATA_UNMAPPED  16'h0000

// Event bit positions, shared by the flag, mask and clear registers.
`define GIMC_BIT_HOT_EVENT        0
`define GIMC_BIT_PACK_LINK_FAULT  1
`define GIMC_BIT_LOW_VOLT_EVENT   2
`define GIMC_BIT_CHARGE_HIGH      3
`define GIMC_BIT_COLD_EVENT       4
`define GIMC_BIT_PERIODIC_TICK    5
`define GIMC_BIT_BOUNDS_CHECK     6
`define GIMC_BIT_CHARGE_EMPTY     7
`define GIMC_BIT_CHARGE_LOW_ENTER 8
`define GIMC_BIT_CHARGE_LOW_EXIT  9
`define GIMC_BIT_GAUGE_RUNNING    10
`define GIMC_BIT_SETUP_READY      11
`define GIMC_BIT_GUARD_TIMER      12
`define GIMC_BIT_BUS_CONTROLLER   13
`define GIMC_BIT_NEAR_FULL        14
`define GIMC_BIT_PACK_LEVEL       15

`endif

// file: gimc_gauge_interrupt_mask_clear.v
`timescale 1ns/10ps
`include "gimc_consts.vh"

//
// Function
// (RULE1) Mask bits 0,1: hot, pack link; 1 masks.
// (RULE2) Mask bits 2-4: low volt, high, cold.
// (RULE3) Mask bits 5-7: tick, bounds, empty.
// (RULE4) Mask bits 8,9: charge low enter, exit.
// (RULE5) Mask bits 10-12: running, setup, guard timer.
// (RULE6) Mask bits 13-15: bus, near full, pack level.
// (RULE7) Sixteen-bit clear register at 0x0C, resets zero.
// (RULE8) Writing zero to a clear bit does nothing.
// (RULE9) Writing one clears flag, clear bit self-clears.
// (RULE10) Clear bit n clears flag bit n.
// (RULE11) Clear bit 1 clears pack link fault flag.
// (RULE12) Clear bit 14 clears near full flag.
// (RULE13) Flags sticky; interrupt when any unmasked flag set.
// (RULE14) Host clears only flags it has handled.
module gimc_gauge_interrupt_mask_clear
#(
  parameter REG_W  = `GIMC_REG_W,
  parameter ADDR_W = `GIMC_ADDR_W
)
(
  // Clock and reset.
  input  wire              sys_clk,
  input  wire              rst_b,
  // Register port from the serial target logic.
  input  wire [ADDR_W-1:0] reg_addr,
  input  wire [REG_W-1:0]  reg_wdata,
  input  wire              reg_wr,
  input  wire              reg_rd,
  output reg  [REG_W-1:0]  reg_rdata,
  output reg               reg_rvalid,
  // Event pulses from the gauge core, one bit per event source.
  input  wire [REG_W-1:0]  event_pulse,
  // Interrupt and state views.
  output wire              gauge_irq,
  output wire [REG_W-1:0]  event_flags,
  output wire [REG_W-1:0]  event_flag_mask,
  output wire [REG_W-1:0]  event_pending
);

  // Register storage.
  reg  [REG_W-1:0] flags_q;
  reg  [REG_W-1:0] flags_d;
  reg  [REG_W-1:0] mask_q;
  reg  [REG_W-1:0] mask_d;
  reg  [REG_W-1:0] event_flag_clear_q;
  reg  [REG_W-1:0] event_flag_clear_d;
  reg  [REG_W-1:0] rdata_d;
  wire [REG_W-1:0] clear_hit;

  // Named views of the mask bits, one wire per event source.
  wire             hot_event_mask;
  wire             pack_link_fault_mask;
  wire             low_volt_event_mask;
  wire             charge_high_mask;
  wire             cold_event_mask;
  wire             periodic_tick_mask;
  wire             bounds_check_mask;
  wire             charge_empty_mask;
  wire             charge_low_enter_mask;
  wire             charge_low_exit_mask;
  wire             gauge_running_mask;
  wire             setup_ready_mask;
  wire             guard_timer_mask;
  wire             bus_controller_mask;
  wire             near_full_mask;
  wire             pack_level_mask;

  // Named views of the self-clearing clear bits, one wire per event source.
  wire             hot_event_clear;
  wire             pack_link_fault_clear;
  wire             low_volt_event_clear;
  wire             charge_high_clear;
  wire             cold_event_clear;
  wire             periodic_tick_clear;
  wire             bounds_check_clear;
  wire             charge_empty_clear;
  wire             charge_low_enter_clear;
  wire             charge_low_exit_clear;
  wire             gauge_running_clear;
  wire             setup_ready_clear;
  wire             guard_timer_clear;
  wire             bus_controller_clear;
  wire             near_full_clear;
  wire             pack_level_clear;

  // Vectors rebuilt from the named bits; the pending and flag logic read these.
  wire [REG_W-1:0] mask_view;
  wire [REG_W-1:0] clear_view;

  // Write strobes, decoded once per writable register.
  wire             mask_wr;
  wire             clear_wr;

  // Decodes a register offset; used by the write and read paths.
  function addr_is;
    input [ADDR_W-1:0] addr;
    input [ADDR_W-1:0] ofs;
    begin
      addr_is = (addr == ofs);
    end
  endfunction

  // Write strobes; a write to the flag register or an unmapped offset has no target.
  assign mask_wr  = reg_wr && addr_is(reg_addr, `GIMC_OFS_MASK);
  assign clear_wr = reg_wr && addr_is(reg_addr, `GIMC_OFS_CLEAR);

  // Mask bits 0 to 7; a one keeps the event away from the interrupt.
  assign hot_event_mask         = mask_q[`GIMC_BIT_HOT_EVENT]; // [RULE1]
  assign pack_link_fault_mask   = mask_q[`GIMC_BIT_PACK_LINK_FAULT]; // [RULE1]
  assign low_volt_event_mask    = mask_q[`GIMC_BIT_LOW_VOLT_EVENT]; // [RULE2]
  assign charge_high_mask       = mask_q[`GIMC_BIT_CHARGE_HIGH]; // [RULE2]
  assign cold_event_mask        = mask_q[`GIMC_BIT_COLD_EVENT]; // [RULE2]
  assign periodic_tick_mask     = mask_q[`GIMC_BIT_PERIODIC_TICK]; // [RULE3]
  assign bounds_check_mask      = mask_q[`GIMC_BIT_BOUNDS_CHECK]; // [RULE3]
  assign charge_empty_mask      = mask_q[`GIMC_BIT_CHARGE_EMPTY]; // [RULE3]

  // Mask bits 8 to 15, with the same polarity.
  assign charge_low_enter_mask  = mask_q[`GIMC_BIT_CHARGE_LOW_ENTER]; // [RULE4]
  assign charge_low_exit_mask   = mask_q[`GIMC_BIT_CHARGE_LOW_EXIT]; // [RULE4]
  assign gauge_running_mask     = mask_q[`GIMC_BIT_GAUGE_RUNNING]; // [RULE5]
  assign setup_ready_mask       = mask_q[`GIMC_BIT_SETUP_READY]; // [RULE5]
  assign guard_timer_mask       = mask_q[`GIMC_BIT_GUARD_TIMER]; // [RULE5]
  assign bus_controller_mask    = mask_q[`GIMC_BIT_BUS_CONTROLLER]; // [RULE6]
  assign near_full_mask         = mask_q[`GIMC_BIT_NEAR_FULL]; // [RULE6]
  assign pack_level_mask        = mask_q[`GIMC_BIT_PACK_LEVEL]; // [RULE6]

  // Clear bits 0 to 7; bit 1 maps to flag bit 1 like every other bit.
  assign hot_event_clear        = event_flag_clear_q[`GIMC_BIT_HOT_EVENT]; // [RULE10]
  assign pack_link_fault_clear  = event_flag_clear_q[`GIMC_BIT_PACK_LINK_FAULT]; // [RULE11]
  assign low_volt_event_clear   = event_flag_clear_q[`GIMC_BIT_LOW_VOLT_EVENT]; // [RULE10]
  assign charge_high_clear      = event_flag_clear_q[`GIMC_BIT_CHARGE_HIGH]; // [RULE10]
  assign cold_event_clear       = event_flag_clear_q[`GIMC_BIT_COLD_EVENT]; // [RULE10]
  assign periodic_tick_clear    = event_flag_clear_q[`GIMC_BIT_PERIODIC_TICK]; // [RULE10]
  assign bounds_check_clear     = event_flag_clear_q[`GIMC_BIT_BOUNDS_CHECK]; // [RULE10]
  assign charge_empty_clear     = event_flag_clear_q[`GIMC_BIT_CHARGE_EMPTY]; // [RULE10]

  // Clear bits 8 to 15.
  assign charge_low_enter_clear = event_flag_clear_q[`GIMC_BIT_CHARGE_LOW_ENTER]; // [RULE10]
  assign charge_low_exit_clear  = event_flag_clear_q[`GIMC_BIT_CHARGE_LOW_EXIT]; // [RULE10]
  assign gauge_running_clear    = event_flag_clear_q[`GIMC_BIT_GAUGE_RUNNING]; // [RULE10]
  assign setup_ready_clear      = event_flag_clear_q[`GIMC_BIT_SETUP_READY]; // [RULE10]
  assign guard_timer_clear      = event_flag_clear_q[`GIMC_BIT_GUARD_TIMER]; // [RULE10]
  assign bus_controller_clear   = event_flag_clear_q[`GIMC_BIT_BUS_CONTROLLER]; // [RULE10]
  assign near_full_clear        = event_flag_clear_q[`GIMC_BIT_NEAR_FULL]; // [RULE12]
  assign pack_level_clear       = event_flag_clear_q[`GIMC_BIT_PACK_LEVEL]; // [RULE10]

  // Mask vector for the pending logic, bit 15 first.
  // The named bits fix the order, so a shuffled define cannot slip a bit unnoticed.
  assign mask_view = {
    pack_level_mask,
    near_full_mask,
    bus_controller_mask,
    guard_timer_mask,
    setup_ready_mask,
    gauge_running_mask,
    charge_low_exit_mask,
    charge_low_enter_mask,
    charge_empty_mask,
    bounds_check_mask,
    periodic_tick_mask,
    cold_event_mask,
    charge_high_mask,
    low_volt_event_mask,
    pack_link_fault_mask,
    hot_event_mask
  };

  // Clear vector for the flag update, bit 15 first.
  assign clear_view = {
    pack_level_clear,
    near_full_clear,
    bus_controller_clear,
    guard_timer_clear,
    setup_ready_clear,
    gauge_running_clear,
    charge_low_exit_clear,
    charge_low_enter_clear,
    charge_empty_clear,
    bounds_check_clear,
    periodic_tick_clear,
    cold_event_clear,
    charge_high_clear,
    low_volt_event_clear,
    pack_link_fault_clear,
    hot_event_clear
  };

  // Each clear bit targets the flag at the same position, including bit 1 and bit 14.
  genvar i;
  generate
    for (i = 0; i < REG_W; i = i + 1)
    begin : g_clear_map
      assign clear_hit[i] = clear_view[i]; // [RULE10] [RULE11] [RULE12]
    end
  endgenerate

  // Mask register is plain read/write; a one blocks its event.
  always @*
  begin
    mask_d = mask_q;
    if (mask_wr)
    begin
      mask_d = reg_wdata; // [RULE1] [RULE2] [RULE3] [RULE4] [RULE5] [RULE6]
    end
  end

  // Clear register keeps only written ones, for one cycle, then returns to zero.
  always @*
  begin
    event_flag_clear_d = {REG_W{1'h0}}; // [RULE9]
    if (clear_wr)
    begin
      event_flag_clear_d = reg_wdata; // [RULE7] [RULE8]
    end
  end

  // Sticky flags; an event arriving with its clear still sets the flag.
  always @*
  begin
    flags_d = (flags_q & ~clear_hit) | event_pulse; // [RULE9] [RULE13]
  end

  // Read data mux; unmapped offsets read as zero.
  always @*
  begin
    rdata_d = `GIMC_RDATA_UNMAPPED;
    if (addr_is(reg_addr, `GIMC_OFS_FLAGS))
    begin
      rdata_d = flags_q;
    end
    else if (addr_is(reg_addr, `GIMC_OFS_MASK))
    begin
      rdata_d = mask_q;
    end
    else if (addr_is(reg_addr, `GIMC_OFS_CLEAR))
    begin
      rdata_d = event_flag_clear_q;
    end
  end

  // State registers with synchronous reset.
  always @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      flags_q            <= `GIMC_FLAGS_RST;
      mask_q             <= `GIMC_MASK_RST;
      event_flag_clear_q <= `GIMC_CLEAR_RST; // [RULE7]
      reg_rdata          <= `GIMC_RDATA_UNMAPPED;
      reg_rvalid         <= 1'h0;
    end
    else
    begin
      flags_q            <= flags_d;
      mask_q             <= mask_d;
      event_flag_clear_q <= event_flag_clear_d;
      reg_rvalid         <= reg_rd;
      if (reg_rd)
      begin
        reg_rdata <= rdata_d;
      end
    end
  end

  // Interrupt is any set flag whose mask bit is zero.
  // A flag stays set until the host clears it; its pending bit follows the current mask bit.
  generate
    for (i = 0; i < REG_W; i = i + 1)
    begin : g_pending
      assign event_pending[i] = flags_q[i] & ~mask_view[i]; // [RULE13]
    end
  endgenerate
  assign gauge_irq       = |event_pending; // [RULE13]
  assign event_flags     = flags_q;
  assign event_flag_mask = mask_q;

endmodule

// file: gimc_host.sv
`timescale 1ns/10ps
// Host model: one register request per clock edge, taken at the following edge.
module gimc_host
(
  // Clock and register requests.
  input  wire         sys_clk,
  output logic        reg_wr,
  output logic        reg_rd,
  output logic [7:0]  reg_addr,
  output logic [15:0] reg_wdata
);
  // Idle at time zero.
  initial {reg_wr, reg_rd, reg_addr, reg_wdata} = 0;
  // Write data is scrambled when not writing, so stale values never look valid.
  task op(input logic w, r, input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= w ? d : ~reg_wdata;
  endtask
endmodule

// file: tb.sv
`timescale 1ns/10ps
// Random host traffic and events against a reference model.
module tb;
  logic sys_clk = 0, rst_b = 0, reg_wr, reg_rd, reg_rvalid, gauge_irq, m_v;
  logic [7:0] reg_addr;
  logic [15:0] event_pulse = 0, reg_wdata, reg_rdata, event_flags, event_flag_mask;
  logic [15:0] event_pending, m_f, m_m, m_c, m_r, handled;
  int failures = 0, comparisons = 0;
  gimc_host host_u (.*);
  gimc_gauge_interrupt_mask_clear dut_u (.*);
  // Clock at 50 MHz.
  always #10 sys_clk = ~sys_clk;
  // Reference model; set wins over a clear landing in the same cycle.
  always @(posedge sys_clk)
  begin
    m_v <= reg_rd & rst_b;
    if (reg_rd)
      m_r <= reg_addr == 8'h0A ? m_f : reg_addr == 8'h0B ? m_m : reg_addr == 8'h0C ? m_c : 0;
    m_f <= rst_b ? m_f & ~m_c | event_pulse : 0;
    m_m <= !rst_b ? 0 : reg_wr && reg_addr == 8'h0B ? reg_wdata : m_m;
    m_c <= rst_b && reg_wr && reg_addr == 8'h0C ? reg_wdata : 0;
    #1;
    chk({reg_rvalid, gauge_irq, event_pending, event_flags}, {m_v, |(m_f & ~m_m), m_f & ~m_m, m_f});
    if (m_v) chk(reg_rdata, m_r);
  end
  // Compares one result and counts it.
  task chk(input logic [33:0] s, e);
    comparisons++;
    failures += s !== e;
    if (s !== e) $display("CHECK FAILED %0t got %h want %h", $time, s, e);
  endtask
  // Prints the verdict and ends the run.
  task test_done;
    if (failures == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Reset, then random reads and writes over mapped and unmapped offsets.
  initial
  begin
    void'($urandom(3));
    repeat (12) @(posedge sys_clk);
    rst_b <= 1;
    repeat (900)
    begin
      host_u.op($urandom % 2, $urandom % 2, 8'h09 + 8'($urandom % 5), $urandom);
      event_pulse <= $urandom & $urandom & $urandom;
    end
    // Handled flags are read, then only those are written back to the clear register.
    host_u.op(0, 0, 8'h0A, 0);
    event_pulse <= 16'h0002 | 16'($urandom);
    host_u.op(0, 1, 8'h0A, 0);
    event_pulse <= 0;
    host_u.op(0, 0, 8'h0A, 0);
    @(negedge sys_clk) handled = reg_rdata;
    chk(handled & 16'h0002, 16'h0002);
    host_u.op(1, 0, 8'h0C, handled);
    repeat (2) host_u.op(0, 0, 8'h0A, 0);
    @(negedge sys_clk) chk(event_flags & handled, 0);
    test_done();
  end
endmodule
